// File: hdl/adc_ctrl_pkg.sv
// constants for the converter control block
package adc_ctrl_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int RESULT_WIDTH  = 12;
	localparam int ADDR_WIDTH    = 4;
	localparam int LATCH_WIDTH   = RESULT_WIDTH + ADDR_WIDTH;
	localparam int CHANNEL_COUNT = 8;
	localparam int SEL_WIDTH     = 3;
	localparam int STEP_WIDTH    = 4;
	localparam int CALC_WIDTH    = 16;

	// ----------------------------------------------------------------
	// synchronised configuration word fields
	// ----------------------------------------------------------------
	localparam int CFG_PAIR_INPUT_SELECT_BIT  = 5;
	localparam int CFG_ADDR_MSB  = 4;
	localparam int CFG_ADDR_LSB  = 2;
	localparam int CFG_BIP_BIT   = 1;
	localparam int CFG_GAIN_BIT  = 0;

	// ----------------------------------------------------------------
	// codes and reset values
	// ----------------------------------------------------------------
	localparam logic [STEP_WIDTH-1:0]   MSB_STEP    = 4'hB;
	localparam logic [STEP_WIDTH-1:0]   LSB_STEP    = 4'h0;
	localparam logic [RESULT_WIDTH-1:0] SAR_CLEAR   = 12'h000;
	localparam logic [RESULT_WIDTH-1:0] CODE_MAX    = 12'hFFF;
	localparam logic [CALC_WIDTH-1:0]   BIPOLAR_MID = 16'h0800;
	localparam logic [LATCH_WIDTH-1:0]  LATCH_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLOCK_PERIOD_NS = 40;
	localparam int ACQUIRE_MIN_NS  = 150;
	localparam int ACQUIRE_CYCLES  = (ACQUIRE_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

	// ----------------------------------------------------------------
	// sequencing states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_ACQUIRE = 3'b001,
		ST_CONVERT = 3'b010,
		ST_LATCH   = 3'b100
	} conv_state_t;

endpackage

// File: hdl/adc_conversion_mux_control.sv
// successive approximation control, input mux selection and output latch
// ----------------------------------------------------------------
// Notes on behaviour
// - conversions start only via select and start
// - approximation register cleared when conversion begins
// - start requests ignored while converting
// - one bit per step, msb to lsb
// - result and address latched together at end
// - result is positive minus negative mux output
// - pairing low single-ended, high four pairs
// - single-ended: input n positive, common negative
// - pairs: upper bits pick pair, bit0 polarity
// - gain select high gives gain of one
// - gain select low gives gain of two
// - polarity low unipolar, high bipolar span
// - conversion begins on start falling edge
// - start ignored unless chip select low
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module adc_conversion_mux_control
	import adc_ctrl_pkg::*;
(
	// clock, reset, enable
	input  wire logic                                     mclk_i,
	input  wire logic                                     reset_n_i,
	input  wire logic                                     clk_en_i,
	// control pins
	input  wire logic                                     chip_select_n_i,
	input  wire logic                                     conversion_start_n_i,
	// configuration pins
	input  wire logic                                     pair_input_select_i,
	input  wire logic [SEL_WIDTH-1:0]                     channel_address_i,
	input  wire logic                                     polarity_select_i,
	input  wire logic                                     gain_range_select_i,
	// sampled input levels, same clock domain
	input  wire logic [CHANNEL_COUNT-1:0][RESULT_WIDTH-1:0] analog_inputs_i,
	input  wire logic [RESULT_WIDTH-1:0]                  common_input_i,
	// results
	output logic                                          busy_o,
	output logic                                          done_o,
	output logic [LATCH_WIDTH-1:0]                        output_latch_o
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                     cs_meta;
		logic                     cs_sync;
		logic                     start_meta;
		logic                     start_sync;
		logic                     start_prev;
		logic [ADDR_WIDTH+1:0]    cfg_meta;
		logic [ADDR_WIDTH+1:0]    cfg_sync;
		conv_state_t              state;
		logic [RESULT_WIDTH-1:0]  approximation_register;
		logic [STEP_WIDTH-1:0]    step;
		logic [RESULT_WIDTH-1:0]  target;
		logic [ADDR_WIDTH-1:0]    addr_hold;
		logic [LATCH_WIDTH-1:0]   latch;
		logic                     busy;
		logic                     done;
	} ctrl_t;

	ctrl_t r;
	ctrl_t next_r;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [RESULT_WIDTH-1:0] clamp_code(input logic signed [CALC_WIDTH-1:0] v);
		if (v < 0)
			return SAR_CLEAR;
		else if (v > $signed({4'h0, CODE_MAX}))
			return CODE_MAX;
		else
			return v[RESULT_WIDTH-1:0];
	endfunction

	function automatic logic [RESULT_WIDTH-1:0] weight(input logic [STEP_WIDTH-1:0] s);
		return RESULT_WIDTH'(1) << s;
	endfunction

	// ----------------------------------------------------------------
	// input multiplexer and span scaling
	// ----------------------------------------------------------------
	logic                           cfg_pair_input_select;
	logic [SEL_WIDTH-1:0]           cfg_addr;
	logic                           cfg_bip;
	logic                           cfg_gain1;
	logic [RESULT_WIDTH-1:0]        pos_level;
	logic [RESULT_WIDTH-1:0]        neg_level;
	logic signed [CALC_WIDTH-1:0]   span_value;
	logic                           start_fall;

	assign cfg_pair_input_select  = r.cfg_sync[CFG_PAIR_INPUT_SELECT_BIT];
	assign cfg_addr  = r.cfg_sync[CFG_ADDR_MSB:CFG_ADDR_LSB];
	assign cfg_bip   = r.cfg_sync[CFG_BIP_BIT];
	assign cfg_gain1 = r.cfg_sync[CFG_GAIN_BIT];

	always_comb begin
		if (cfg_pair_input_select) begin
			pos_level = analog_inputs_i[{cfg_addr[2:1], cfg_addr[0]}];
			neg_level = analog_inputs_i[{cfg_addr[2:1], ~cfg_addr[0]}];
		end else begin
			pos_level = analog_inputs_i[cfg_addr];
			neg_level = common_input_i;
		end
		span_value = $signed({4'h0, pos_level}) - $signed({4'h0, neg_level});
		if (!cfg_gain1)
			span_value = span_value <<< 1;
		if (cfg_bip)
			span_value = span_value + $signed(BIPOLAR_MID);
	end

	// edge seen on synced levels only, gated by select
	assign start_fall = r.start_prev && !r.start_sync && !r.cs_sync;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_r            = r;
		next_r.cs_meta    = chip_select_n_i;
		next_r.cs_sync    = r.cs_meta;
		next_r.start_meta = conversion_start_n_i;
		next_r.start_sync = r.start_meta;
		next_r.start_prev = r.start_sync;
		next_r.cfg_meta   = {pair_input_select_i, channel_address_i,
		                     polarity_select_i, gain_range_select_i};
		next_r.cfg_sync   = r.cfg_meta;
		next_r.done       = 1'b0;
		unique case (r.state)
			ST_ACQUIRE: begin
				if (start_fall) begin
					next_r.state     = ST_CONVERT;
					next_r.approximation_register       = SAR_CLEAR;
					next_r.step      = MSB_STEP;
					next_r.target    = clamp_code(span_value);
					next_r.addr_hold = {cfg_pair_input_select, cfg_addr};
					next_r.busy      = 1'b1;
				end
			end
			ST_CONVERT: begin
				// start edges are not looked at here
				if ((r.approximation_register | weight(r.step)) <= r.target)
					next_r.approximation_register = r.approximation_register | weight(r.step);
				if (r.step == LSB_STEP)
					next_r.state = ST_LATCH;
				else
					next_r.step = r.step - STEP_WIDTH'(1);
			end
			ST_LATCH: begin
				next_r.latch = {r.addr_hold, r.approximation_register};
				next_r.state = ST_ACQUIRE;
				next_r.busy  = 1'b0;
				next_r.done  = 1'b1;
			end
			default: begin
				next_r.state = ST_ACQUIRE;
				next_r.busy  = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			r            <= '0;
			r.cs_meta    <= 1'b1;
			r.cs_sync    <= 1'b1;
			r.start_meta <= 1'b1;
			r.start_sync <= 1'b1;
			r.start_prev <= 1'b1;
			r.state      <= ST_ACQUIRE;
			r.latch      <= LATCH_RESET;
		end else if (clk_en_i) begin
			r <= next_r;
		end
	end

	assign busy_o         = r.busy;
	assign done_o         = r.done;
	assign output_latch_o = r.latch;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);

	sequence start_taken;
		clk_en_i && r.state == ST_ACQUIRE && start_fall;
	endsequence

	sequence last_step;
		clk_en_i && r.state == ST_CONVERT && r.step == LSB_STEP;
	endsequence

	a_start_clears_sar: assert property (
		start_taken |=> r.approximation_register == SAR_CLEAR && r.step == MSB_STEP && busy_o)
		else $error("conversion did not start with cleared register at msb");

	a_start_needs_select: assert property (
		clk_en_i && r.state == ST_ACQUIRE && r.cs_sync |=> r.state == ST_ACQUIRE)
		else $error("conversion began without chip select");

	a_no_restart: assert property (
		clk_en_i && r.state == ST_CONVERT && r.step != LSB_STEP
		|=> r.state == ST_CONVERT && r.step == $past(r.step) - STEP_WIDTH'(1))
		else $error("running conversion was disturbed");

	a_bits_settled: assert property (
		clk_en_i && r.state == ST_CONVERT |=> (r.approximation_register & (weight($past(r.step)) - 12'h001)) == 12'h000)
		else $error("lower bits decided early");

	a_last_to_latch: assert property (
		last_step ##1 (clk_en_i && r.state == ST_LATCH)
		|=> output_latch_o == {$past(r.addr_hold), $past(r.approximation_register)} && done_o && !busy_o)
		else $error("latch not loaded with result and address");

	a_result_exact: assert property (
		r.state == ST_LATCH |-> r.approximation_register == r.target)
		else $error("result differs from selected input difference");

	a_address_capture: assert property (
		start_taken |=> r.addr_hold == $past({cfg_pair_input_select, cfg_addr}))
		else $error("channel address not captured at start");

	a_latch_holds: assert property (
		!(clk_en_i && r.state == ST_LATCH) |=> $stable(output_latch_o))
		else $error("output latch changed outside completion");

	sequence conv_running;
		clk_en_i && r.state == ST_CONVERT;
	endsequence

	a_busy_in_convert: assert property (
		conv_running |-> busy_o)
		else $error("busy low during conversion");

	a_idle_not_busy: assert property (
		r.state == ST_ACQUIRE |-> !busy_o)
		else $error("busy high in acquire phase");

	a_latch_to_idle: assert property (
		clk_en_i && r.state == ST_LATCH |=> r.state == ST_ACQUIRE)
		else $error("latch phase did not return to acquire");

	a_state_legal: assert property (
		$onehot(r.state))
		else $error("sequencing state code illegal");

	a_step_range: assert property (
		conv_running |-> r.step <= MSB_STEP)
		else $error("bit step outside result width");

	a_start_on_fall: assert property (
		clk_en_i && r.state == ST_ACQUIRE && !(r.start_prev && !r.start_sync)
		|=> r.state == ST_ACQUIRE)
		else $error("conversion began without a start falling edge");

	a_freeze_holds: assert property (
		!clk_en_i |=> $stable(r))
		else $error("state moved while clock enable low");

	// ----------------------------------------------------------------
	// completion pulse and output latch checks
	// ----------------------------------------------------------------
	a_done_single: assert property (
		clk_en_i && done_o |=> !done_o)
		else $error("completion pulse longer than one cycle");

	a_done_not_busy: assert property (
		done_o |-> !busy_o)
		else $error("busy still high at completion");

	a_latch_address: assert property (
		done_o |-> output_latch_o[LATCH_WIDTH-1:RESULT_WIDTH] == r.addr_hold)
		else $error("latched address differs from captured address");

	a_latch_result: assert property (
		done_o |-> output_latch_o[RESULT_WIDTH-1:0] == r.target)
		else $error("latched result differs from input difference");

	// ----------------------------------------------------------------
	// multiplexer checks
	// ----------------------------------------------------------------
	a_pos_channel: assert property (
		pos_level == analog_inputs_i[cfg_addr])
		else $error("positive input not the addressed channel");

	a_neg_pair: assert property (
		cfg_pair_input_select |-> neg_level == analog_inputs_i[cfg_addr ^ 3'h1])
		else $error("negative input not the pair partner");

	a_neg_common: assert property (
		!cfg_pair_input_select |-> neg_level == common_input_i)
		else $error("negative input not the common return");

endmodule

`default_nettype wire

// File: tb/adc_host_model.sv
// host model driving the converter control and configuration pins
`timescale 1ns/1ps
`default_nettype none
module adc_host_model
	import adc_ctrl_pkg::*;
(
	// clock and device outputs
	input  wire logic                 mclk_i,
	input  wire logic                 done_i,
	// control pins
	output logic                      chip_select_n_o,
	output logic                      conversion_start_n_o,
	// configuration pins
	output logic                      pair_o,
	output logic [SEL_WIDTH-1:0]      addr_o,
	output logic                      polarity_o,
	output logic                      gain_o
);
	initial begin
		chip_select_n_o = 1'b1;
		conversion_start_n_o = 1'b1;
		{pair_o, addr_o, polarity_o, gain_o} = 6'h00;
	end

	// one conversion; cycles is 0 when no completion came
	task automatic convert(input logic [3:0] k, input logic gain, input logic pol,
		input logic cs_n, input logic restart, output int cycles);
		int n;
		@(negedge mclk_i);
		pair_o = k[3];
		addr_o = k[2:0];
		polarity_o = pol;
		gain_o = gain;
		repeat (ACQUIRE_CYCLES) @(negedge mclk_i);
		chip_select_n_o = cs_n;
		conversion_start_n_o = 1'b0;
		cycles = 0;
		for (n = 1; n <= 40 && cycles == 0; n++) begin
			@(negedge mclk_i);
			if (restart && n == 6) conversion_start_n_o = 1'b1;
			if (restart && n == 9) conversion_start_n_o = 1'b0;
			if (done_i === 1'b1) cycles = n;
		end
		conversion_start_n_o = 1'b1;
		chip_select_n_o = 1'b1;
	endtask
endmodule
`default_nettype wire

// File: tb/adc_conversion_mux_control_bench.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_mux_control_bench;
	import adc_ctrl_pkg::*;
	logic                                   mclk_i;
	logic                                   reset_n_i;
	logic                                   cs_n, start_n, pair, pol, gain, busy, done, en;
	logic [SEL_WIDTH-1:0]                   addr;
	logic [CHANNEL_COUNT-1:0][RESULT_WIDTH-1:0] levels;
	logic [RESULT_WIDTH-1:0]                common;
	logic [LATCH_WIDTH-1:0]                 latch;
	int                                     error_cnt, cmp_count, c1, c2, k;
	int                                     busy_hits, done_hits;

	adc_conversion_mux_control uut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .clk_en_i(en),
		.chip_select_n_i(cs_n), .conversion_start_n_i(start_n), .pair_input_select_i(pair),
		.channel_address_i(addr), .polarity_select_i(pol), .gain_range_select_i(gain),
		.analog_inputs_i(levels), .common_input_i(common), .busy_o(busy), .done_o(done),
		.output_latch_o(latch));
	adc_host_model host (.mclk_i(mclk_i), .done_i(done), .chip_select_n_o(cs_n),
		.conversion_start_n_o(start_n), .pair_o(pair), .addr_o(addr),
		.polarity_o(pol), .gain_o(gain));

	// cycles with busy and done high, seen where they are settled
	always @(negedge mclk_i) begin
		if (busy === 1'b1) busy_hits++;
		if (done === 1'b1) done_hits++;
	end

	function automatic int level(input int c);
		return c * 'h1F0 + 'h40;
	endfunction

	// expected latch: positive minus negative, gain, offset, clamp
	function automatic logic [LATCH_WIDTH-1:0] expect_latch(input int k);
		int v;
		v = level(k % 8) - ((k >= 8) ? level((k % 8) ^ 1) : 'h50);
		v = v * ((k[0] ^ k[3]) ? 1 : 2);
		v = v + ((k[1] ^ k[2]) ? 2048 : 0);
		v = (v < 0) ? 0 : ((v > 4095) ? 4095 : v);
		return {k[3], k[2:0], v[11:0]};
	endfunction

	task automatic check(input logic [LATCH_WIDTH-1:0] got, input logic [LATCH_WIDTH-1:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic results();
		$display("Comparisons %0d, errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end

	initial begin
		error_cnt = 0;
		cmp_count = 0;
		busy_hits = 0;
		done_hits = 0;
		en = 1'b1;
		reset_n_i = 1'b0;
		common = 12'h050;
		for (k = 0; k < CHANNEL_COUNT; k++) levels[k] = 12'(level(k));
		repeat (3) @(negedge mclk_i);
		reset_n_i = 1'b1;
		check(latch, LATCH_RESET);
		check({14'h0000, busy, done}, 16'h0000);
		// every address in both pairings, all gain and polarity mixes
		for (k = 0; k < 16; k++) begin
			host.convert(4'(k), k[0] ^ k[3], k[1] ^ k[2], 1'b0, 1'b0, c1);
			check(16'(c1 != 0), 16'h0001);
			check(latch, expect_latch(k));
			check({15'h0000, busy}, 16'h0000);
		end
		// second start edge in mid-conversion leaves timing alone
		host.convert(4'h5, 1'b1, 1'b1, 1'b0, 1'b1, c2);
		check(16'(c2), 16'(c1));
		check(latch, expect_latch(5));
		for (k = 0; k < 20; k++) begin
			@(negedge mclk_i);
			if (done === 1'b1) c2 = 0;
		end
		check(16'(c2), 16'(c1));
		// start without chip select is ignored, latch holds
		host.convert(4'hA, 1'b0, 1'b1, 1'b1, 1'b0, c2);
		check(16'(c2), 16'h0000);
		check(latch, expect_latch(5));
		// clock enable low mid-conversion stretches it by the frozen edges
		fork
			host.convert(4'h3, 1'b1, 1'b1, 1'b0, 1'b0, c2);
			begin
				repeat (10) @(negedge mclk_i);
				en = 1'b0;
				repeat (5) @(negedge mclk_i);
				en = 1'b1;
			end
		join
		check(16'(c2), 16'(c1 + 5));
		check(latch, expect_latch(3));
		@(negedge mclk_i);
		check(16'(done_hits), 16'(18));
		check(16'(busy_hits), 16'((RESULT_WIDTH + 1) * 18 + 5));
		results();
	end
endmodule
`default_nettype wire
